/* hw/boot_strap_pkg.sv */
// Constants and types shared by the boot strap latch design.
package boot_strap_pkg;
    localparam int STRAP_COUNT = 5;
    // Bit positions inside the captured strap vector.
    localparam int BIT_TEST_DATA_IN = 0;
    localparam int BIT_GENERAL_IO_ZERO = 1;
    localparam int BIT_GENERAL_IO_TWO = 2;
    localparam int BIT_TEST_DATA_OUT = 3;
    localparam int BIT_GENERAL_IO_FIVE = 4;
    // Weak pull levels applied while in reset; 1 means pull-up.
    localparam logic [4:0] PULL_UP_MASK = 5'h1A;
    localparam logic [4:0] STRAP_RESET_VALUE = 5'h1A;
    localparam int SYNC_STAGES = 2;
    typedef enum logic {LDO_3V3, LDO_1V8} ldo_sel_type;
    typedef enum logic {BOOT_DOWNLOAD, BOOT_SPI_FLASH} boot_mode_type;
    typedef enum {ST_RESET, ST_SETTLE, ST_RUN} latch_state_type;
endpackage

/* hw/strap_sync.sv */
// Two-flop synchroniser for one strap pin.
`timescale 1ns/1ps
module strap_sync
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_reg;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            meta_reg <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_in;
            pin_sync <= meta_reg;
        end
    end
endmodule // strap_sync

/* hw/boot_strap_latch.sv */
// Boot strap latch: captures five strap pins at reset release and decodes all but general_io_two.
`timescale 1ns/1ps
module boot_strap_latch
    import boot_strap_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic module_enable,
    input wire logic test_data_in_pin,
    input wire logic general_io_zero,
    input wire logic general_io_two,
    input wire logic test_data_out_pin,
    input wire logic general_io_five,
    input wire logic fw_ldo_override,
    input wire logic fw_ldo_sel,
    input wire logic fw_sdio_override,
    input wire logic [1:0] fw_sdio_timing,
    output logic [boot_strap_pkg::STRAP_COUNT-1:0] strap_status,
    output logic [boot_strap_pkg::STRAP_COUNT-1:0] strap_pull_en,
    output logic [boot_strap_pkg::STRAP_COUNT-1:0] strap_pull_up,
    output logic strap_role_active,
    output logic strap_valid,
    output logic ldo_select_1v8,
    output logic boot_spi_flash,
    output logic boot_log_enable,
    output logic sdio_sample_rising,
    output logic sdio_output_rising,
    output logic running
);
    import boot_strap_pkg::*;

    logic [STRAP_COUNT-1:0] pins_raw;
    logic [STRAP_COUNT-1:0] pins_sync;
    logic [STRAP_COUNT-1:0] strap_reg;
    logic [1:0] settle_count_reg;
    logic [1:0] settle_count_next;
    latch_state_type state_reg;
    latch_state_type state_next;
    logic ldo_sel_next;
    logic [1:0] sdio_next;

    assign pins_raw = {general_io_five, test_data_out_pin, general_io_two,
                       general_io_zero, test_data_in_pin};

    // Each pin gets its own synchroniser so strap capture never sees a metastable level.
    for (genvar i = 0; i < STRAP_COUNT; i++)
    begin : g_sync
        strap_sync u_sync
        (
            .mclk(mclk),
            .reset(reset),
            .pin_in(pins_raw[i]),
            .pin_sync(pins_sync[i])
        );
    end

    // The enable acts as a reset too: dropping it returns the chip to the strap phase.
    always_comb
    begin
        state_next = state_reg;
        settle_count_next = settle_count_reg;
        unique case (state_reg)
            ST_RESET:
            begin
                settle_count_next = 2'h0;
                if (module_enable)
                begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                // Waiting for the synchroniser to fill with real pin levels.
                settle_count_next = settle_count_reg + 2'h1;
                if (!module_enable)
                begin
                    state_next = ST_RESET;
                end
                else if (settle_count_reg == 2'(SYNC_STAGES - 1))
                begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (!module_enable)
                begin
                    state_next = ST_RESET;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_RESET;
            settle_count_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            settle_count_reg <= settle_count_next;
        end
    end

    // Capture happens once per run entry, on the edge that leaves the settle phase.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            strap_reg <= STRAP_RESET_VALUE;
            strap_valid <= 1'b0;
        end
        else if (state_reg == ST_SETTLE && state_next == ST_RUN)
        begin
            strap_reg <= pins_sync;
            strap_valid <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            strap_status <= STRAP_RESET_VALUE;
        end
        else
        begin
            strap_status <= strap_reg;
        end
    end

    // Pulls stay on until the strap is taken, then the pins are handed back.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            strap_pull_en <= '1;
            strap_pull_up <= PULL_UP_MASK;
            strap_role_active <= 1'b1;
            running <= 1'b0;
        end
        else
        begin
            strap_pull_en <= (state_next == ST_RUN) ? '0 : '1;
            strap_pull_up <= PULL_UP_MASK;
            strap_role_active <= (state_next != ST_RUN);
            running <= (state_next == ST_RUN);
        end
    end

    // Firmware override replaces the latched regulator and SDIO timing choices; the latched bits stay readable.
    always_comb
    begin
        ldo_sel_next = fw_ldo_override ? fw_ldo_sel : strap_reg[BIT_TEST_DATA_IN];
        sdio_next = fw_sdio_override ? fw_sdio_timing :
            {strap_reg[BIT_TEST_DATA_OUT], strap_reg[BIT_GENERAL_IO_FIVE]};
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            // Before a capture the decodes show what the default pulls would give.
            ldo_select_1v8 <= STRAP_RESET_VALUE[BIT_TEST_DATA_IN];
            boot_spi_flash <= STRAP_RESET_VALUE[BIT_GENERAL_IO_ZERO];
            boot_log_enable <= STRAP_RESET_VALUE[BIT_TEST_DATA_OUT];
            sdio_sample_rising <= STRAP_RESET_VALUE[BIT_TEST_DATA_OUT];
            sdio_output_rising <= STRAP_RESET_VALUE[BIT_GENERAL_IO_FIVE];
        end
        else
        begin
            ldo_select_1v8 <= ldo_sel_next;
            // Pin two is a don't-care whatever pin zero is; only pin zero sets the boot mode.
            boot_spi_flash <= strap_reg[BIT_GENERAL_IO_ZERO];
            boot_log_enable <= strap_reg[BIT_TEST_DATA_OUT];
            sdio_sample_rising <= sdio_next[1];
            sdio_output_rising <= sdio_next[0];
        end
    end

    AST_CAPTURE_ON_RUN: assert property (@(posedge mclk) disable iff (reset)
        (state_reg == ST_SETTLE && state_next == ST_RUN) |=> strap_reg == $past(pins_sync))
        else $error("Strap set not captured at settle exit.");
    AST_HOLD: assert property (@(posedge mclk) disable iff (reset)
        (state_reg == ST_RUN && $past(state_reg) == ST_RUN) |-> $stable(strap_reg))
        else $error("Strap bits changed while running.");
    AST_STATUS: assert property (@(posedge mclk) disable iff (reset)
        ##1 strap_status == $past(strap_reg))
        else $error("Status does not follow latched straps.");
    AST_PULL_RELEASE: assert property (@(posedge mclk) disable iff (reset)
        running |-> strap_pull_en == '0 && !strap_role_active)
        else $error("Pulls still on after release.");
    AST_LDO: assert property (@(posedge mclk) disable iff (reset)
        !$past(fw_ldo_override) |-> ldo_select_1v8 == $past(strap_reg[BIT_TEST_DATA_IN]))
        else $error("Regulator select wrong.");
    AST_LDO_FW: assert property (@(posedge mclk) disable iff (reset)
        $past(fw_ldo_override) |-> ldo_select_1v8 == $past(fw_ldo_sel))
        else $error("Regulator override ignored.");
    AST_BOOT: assert property (@(posedge mclk) disable iff (reset)
        ##1 boot_spi_flash == $past(strap_reg[BIT_GENERAL_IO_ZERO]))
        else $error("Boot mode wrong.");
    AST_LOG: assert property (@(posedge mclk) disable iff (reset)
        ##1 boot_log_enable == $past(strap_reg[BIT_TEST_DATA_OUT]))
        else $error("Boot log enable wrong.");
    AST_SDIO: assert property (@(posedge mclk) disable iff (reset)
        !$past(fw_sdio_override) |-> {sdio_sample_rising, sdio_output_rising} ==
        {$past(strap_reg[BIT_TEST_DATA_OUT]), $past(strap_reg[BIT_GENERAL_IO_FIVE])})
        else $error("SDIO timing wrong.");
    AST_ENABLE: assert property (@(posedge mclk) disable iff (reset)
        !module_enable |=> !running)
        else $error("Running while disabled.");
endmodule // boot_strap_latch

/* dv/strap_pins_model.sv */
// Behavioural model of the pull resistors and host pins that sit on the five strap pins.
`timescale 1ns/1ps
module strap_pins_model
(
    input wire logic [4:0] drive_en,
    input wire logic [4:0] drive_val,
    input wire logic tdi_high_ok,
    input wire logic [4:0] pull_en,
    input wire logic [4:0] pull_up,
    output logic [4:0] pins
);
    logic [4:0] level;
    logic [4:0] last_reg = 5'h00;
    // Never drive a high regulator select unless the bench asks for it on purpose.
    assign level = {drive_val[4:1], drive_val[0] & tdi_high_ok};
    always @*
    begin
        for (int i = 0; i < 5; i++)
        begin
            if (drive_en[i])
                last_reg[i] = level[i];
        end
    end
    // A released pin with no weak pull shows the inverse of its last level, so nothing stale passes.
    assign pins = (drive_en & level) | (~drive_en & pull_en & pull_up)
        | (~drive_en & ~pull_en & ~last_reg);
endmodule // strap_pins_model

/* dv/boot_strap_latch_bench.sv */
// Self-checking testbench for the boot strap latch.
`timescale 1ns/1ps
module boot_strap_latch_bench;
    import boot_strap_pkg::*;
    logic mclk, reset, module_enable, fw_ldo_override, fw_ldo_sel, fw_sdio_override, tdi_ok;
    logic [1:0] fw_sdio_timing;
    logic [4:0] drive_en, drive_val, pins, strap_status, strap_pull_en, strap_pull_up;
    logic strap_role_active, strap_valid, ldo_select_1v8, boot_spi_flash, boot_log_enable;
    logic sdio_sample_rising, sdio_output_rising, running;
    int num_errors = 0;
    int comparisons = 0;
    strap_pins_model strap_pins_model_inst (.drive_en(drive_en), .drive_val(drive_val),
        .tdi_high_ok(tdi_ok), .pull_en(strap_pull_en), .pull_up(strap_pull_up), .pins(pins));
    boot_strap_latch boot_strap_latch_inst (.mclk(mclk), .reset(reset),
        .module_enable(module_enable), .test_data_in_pin(pins[0]), .general_io_zero(pins[1]),
        .general_io_two(pins[2]), .test_data_out_pin(pins[3]), .general_io_five(pins[4]),
        .fw_ldo_override(fw_ldo_override), .fw_ldo_sel(fw_ldo_sel),
        .fw_sdio_override(fw_sdio_override), .fw_sdio_timing(fw_sdio_timing),
        .strap_status(strap_status), .strap_pull_en(strap_pull_en),
        .strap_pull_up(strap_pull_up), .strap_role_active(strap_role_active),
        .strap_valid(strap_valid), .ldo_select_1v8(ldo_select_1v8),
        .boot_spi_flash(boot_spi_flash), .boot_log_enable(boot_log_enable),
        .sdio_sample_rising(sdio_sample_rising), .sdio_output_rising(sdio_output_rising),
        .running(running));
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task summarize;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input string name, input logic [4:0] seen, input logic [4:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Bounded wait for the run state, then two edges so status and decodes have landed.
    task wait_run;
        for (int i = 0; i < 20 && running !== 1'b1; i++)
            @(negedge mclk);
        if (running !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
        else
            repeat (2) @(negedge mclk);
    endtask
    task capture(input logic [4:0] en, input logic [4:0] val, input logic [4:0] exp);
        @(negedge mclk);
        reset = 1'b1;
        drive_en = en;
        drive_val = val;
        repeat (8) @(negedge mclk);
        check("pull_en", strap_pull_en, 5'h1F);
        check("pull_up", strap_pull_up, 5'h1A);
        check("role", {2'h0, strap_role_active, strap_valid, running}, 5'h04);
        reset = 1'b0;
        wait_run();
        check("status", strap_status, exp);
        check("role", {3'h0, strap_role_active, strap_valid}, 5'h01);
        check("pull_en", strap_pull_en, 5'h00);
        check("ldo", 5'(ldo_select_1v8), 5'(exp[0]));
        check("boot", 5'(boot_spi_flash), 5'(exp[1]));
        check("log", 5'(boot_log_enable), 5'(exp[3]));
        check("sdio", {3'h0, sdio_sample_rising, sdio_output_rising}, {3'h0, exp[3], exp[4]});
    endtask
    task test_codes;
        capture(5'h00, 5'h00, 5'h1A);
        tdi_ok = 1'b1;
        for (int v = 0; v < 32; v++)
            capture(5'h1F, 5'(v), 5'(v));
        tdi_ok = 1'b0;
    endtask
    task test_hold;
        drive_val = 5'h00;
        repeat (4) @(negedge mclk);
        check("held", strap_status, 5'h1F);
        drive_en = 5'h00;
        repeat (4) @(negedge mclk);
        check("held", strap_status, 5'h1F);
    endtask
    task test_override;
        capture(5'h1F, 5'h00, 5'h00);
        fw_ldo_override = 1'b1;
        fw_ldo_sel = 1'b1;
        fw_sdio_override = 1'b1;
        for (int t = 0; t < 4; t++)
        begin
            fw_sdio_timing = 2'(t);
            repeat (2) @(negedge mclk);
            check("sdio_fw", {3'h0, sdio_sample_rising, sdio_output_rising}, 5'(t));
        end
        check("ldo_fw", 5'(ldo_select_1v8), 5'h01);
        fw_ldo_override = 1'b0;
        fw_sdio_override = 1'b0;
        repeat (2) @(negedge mclk);
        check("ldo_back", {2'h0, ldo_select_1v8, sdio_sample_rising, sdio_output_rising}, 5'h00);
    endtask
    task test_enable;
        module_enable = 1'b0;
        drive_val = 5'h16;
        repeat (4) @(negedge mclk);
        check("disabled", {3'h0, running, strap_role_active}, 5'h01);
        check("pull_en", strap_pull_en, 5'h1F);
        module_enable = 1'b1;
        wait_run();
        check("recapture", strap_status, 5'h16);
    endtask
    initial
    begin
        reset = 1'b1;
        module_enable = 1'b1;
        fw_ldo_override = 1'b0;
        fw_ldo_sel = 1'b0;
        fw_sdio_override = 1'b0;
        fw_sdio_timing = 2'h0;
        tdi_ok = 1'b0;
        drive_en = 5'h00;
        drive_val = 5'h00;
        test_codes();
        test_hold();
        test_override();
        test_enable();
        summarize();
    end
endmodule // boot_strap_latch_bench
